/* File: src/arc_accum.sv */
// accumulator next-value datapath for the accumulate, average, burst and lowpass modes
// assumes the caller decides when the result is registered
`timescale 1ns/100ps
`default_nettype none
module arc_accum
  import arc_pkg::*;
(
  // control
  input wire logic [2:0] mode,
  input wire logic [2:0] shift,
  input wire logic restart,
  // data
  input wire logic signed [arc_pkg::ACC_W-1:0] acc,
  input wire logic signed [arc_pkg::ACC_W-1:0] sample,
  output logic signed [arc_pkg::ACC_W-1:0] next_acc,
  output logic overflow
);
  logic signed [ACC_W+1:0] wide;
  logic signed [ACC_W-1:0] decay;

  always_comb begin
    decay = arc_ashr(acc, shift);
    if (restart) begin
      wide = (ACC_W+2)'(sample);
    end else if (mode == MODE_LPF) begin
      // two guard bits keep the three-term sum exact
      wide = (ACC_W+2)'(acc) + (ACC_W+2)'(sample) - (ACC_W+2)'(decay); // [RQ8] [RQ10]
    end else begin
      wide = (ACC_W+2)'(acc) + (ACC_W+2)'(sample); // [RQ4]
    end
    next_acc = wide[ACC_W-1:0];
    overflow = (wide[ACC_W+1:ACC_W-1] != 3'h0) && (wide[ACC_W+1:ACC_W-1] != 3'h7);
  end
endmodule
`default_nettype wire

/* File: src/arc_pkg.sv */
// constants, types and shared helpers of the result computation unit
// assumes a 32-bit apb slave and a conversion core on the same clock
package arc_pkg;
  localparam int ACC_W = 16;
  localparam int RES_W = 10;
  localparam int CNT_W = 8;
  localparam int ADDR_W = 8;

  // computation modes
  localparam logic [2:0] MODE_BASIC = 3'h0;
  localparam logic [2:0] MODE_ACCUM = 3'h1;
  localparam logic [2:0] MODE_AVG = 3'h2;
  localparam logic [2:0] MODE_BURST = 3'h3;
  localparam logic [2:0] MODE_LPF = 3'h4;

  // threshold test modes
  localparam logic [2:0] TM_NEVER = 3'h0;
  localparam logic [2:0] TM_BELOW_LO = 3'h1;
  localparam logic [2:0] TM_AT_LEAST_LO = 3'h2;
  localparam logic [2:0] TM_INSIDE = 3'h3;
  localparam logic [2:0] TM_OUTSIDE = 3'h4;
  localparam logic [2:0] TM_AT_MOST_UP = 3'h5;
  localparam logic [2:0] TM_ABOVE_UP = 3'h6;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_REPEAT = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_UPPER = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_LOWER = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_TMODE = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_ACC = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_STAT = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_FILTER = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_RESULT = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_ERROR = 8'h2C;

  // field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SHIFT_LSB = 4;
  localparam int CTRL_DSEN_BIT = 8;
  localparam int CTRL_RCSEL_BIT = 9;
  localparam int CTRL_CLR_BIT = 16;
  localparam int CTRL_GO_BIT = 17;
  localparam int STAT_OVF_BIT = 8;
  localparam int STAT_BUSY_BIT = 9;
  localparam int STAT_PHASE_BIT = 10;
  localparam int RESULT_PREV_LSB = 16;
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_THR = 1;
  localparam int IRQ_OVF = 2;

  // reset values and timing
  localparam logic [CNT_W-1:0] REPEAT_RST = 8'h01;
  localparam logic [ACC_W-1:0] THR_RST = 16'h0000;
  localparam logic [3:0] CLEAR_RC_CYCLES = 4'h5;

  typedef enum logic [1:0] {
    ARC_PH_FIRST = 2'b01,
    ARC_PH_SECOND = 2'b10
  } arc_phase_t;

  // arithmetic shift right: truncates toward the lower value
  function automatic logic signed [ACC_W-1:0] arc_ashr(input logic signed [ACC_W-1:0] v, input logic [2:0] sh);
    return v >>> sh;
  endfunction
endpackage

/* File: src/arc_result_computation.sv */
// post-conversion computation unit: accumulate, average, filter, threshold
// assumes the conversion core pulses conv_valid with its result on clk_sys
// Function
// [RQ1] three-bit mode field picks basic, accumulate, average, burst or lowpass
// [RQ2] basic mode neither accumulates nor compares; double sampling still works
// [RQ3] basic mode flags done after the whole sample sequence, state untouched
// [RQ4] accumulate adds each sample and counts, counter holding at all ones
// [RQ5] accumulate flags done every conversion and tests threshold every sample
// [RQ6] average tests at the repeat target, then restarts count and accumulator
// [RQ7] burst clears on start, reconverts below target, then tests once
// [RQ8] lowpass updates sample plus acc minus shifted acc, tests from target on
// [RQ9] sample is the result, or second minus first with double sampling
// [RQ10] shift divisions truncate toward the lower value, never round
// [RQ11] accumulator is sixteen-bit signed and readable by software
// [RQ12] accumulator clear wipes overflow flag, accumulator and counter
// [RQ13] on the rc oscillator clearing takes five converter cycles
// [RQ14] three-bit shift right-shifts the accumulator into the filter output
// [RQ15] in lowpass the shift sets the filter time constant
// [RQ16] average clears on start when the counter already reached the target
// [RQ17] threshold comparisons are signed
// [RQ18] a set overflow flag signals a threshold interrupt
// [RQ19] sample counter is eight-bit unsigned, readable, saturating at all ones
`timescale 1ns/100ps
`default_nettype none
module arc_result_computation
  import arc_pkg::*;
#(
  parameter int RES_W = arc_pkg::RES_W
)(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // apb slave
  input wire logic [arc_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // conversion core
  input wire logic conv_valid,
  input wire logic [RES_W-1:0] conv_result,
  input wire logic ext_trigger,
  output logic conv_start,
  // interrupt
  output logic irq
);
  // bus state
  logic next_pready;
  logic next_pslverr;
  logic [31:0] next_prdata;
  logic [31:0] rd_word;
  logic mapped;
  logic wr_en;

  // control registers
  logic [2:0] compute_mode_select;
  logic [2:0] shift_amount;
  logic double_sample_enable;
  logic rc_clock_select;
  logic [CNT_W-1:0] repeat_target;
  logic signed [ACC_W-1:0] upper_threshold;
  logic signed [ACC_W-1:0] lower_threshold;
  logic [2:0] threshold_mode;
  logic [IRQ_W-1:0] irq_mask;
  logic [2:0] next_mode;
  logic [2:0] next_shift;
  logic next_dsen;
  logic next_rcsel;
  logic [CNT_W-1:0] next_repeat;
  logic signed [ACC_W-1:0] next_upper;
  logic signed [ACC_W-1:0] next_lower;
  logic [2:0] next_tmode;
  logic [IRQ_W-1:0] next_irq_mask;

  // computation state
  logic signed [ACC_W-1:0] accumulator;
  logic [CNT_W-1:0] sample_counter;
  logic accumulator_overflow_flag;
  logic [RES_W-1:0] conversion_result;
  logic [RES_W-1:0] previous_result;
  arc_phase_t phase;
  logic [3:0] clear_cnt;
  logic [IRQ_W-1:0] irq_status;
  logic signed [ACC_W-1:0] next_accumulator;
  logic [CNT_W-1:0] next_sample_counter;
  logic next_ovf;
  logic [RES_W-1:0] next_result;
  logic [RES_W-1:0] next_prev;
  arc_phase_t next_phase;
  logic [3:0] next_clear_cnt;
  logic [IRQ_W-1:0] next_irq_status;
  logic [IRQ_W-1:0] irq_set;
  logic next_conv_start;
  logic next_irq;

  // datapath wires
  logic signed [ACC_W-1:0] sample;
  logic signed [ACC_W-1:0] acc_sum;
  logic acc_ovf;
  logic restart;
  logic signed [ACC_W-1:0] filter_output;
  logic signed [ACC_W-1:0] error_value;
  logic thr_hit;
  logic accumulator_clear;
  logic conversion_go;
  logic take;
  logic compute;

  assign wr_en = psel && penable && pready && pwrite;
  assign accumulator_clear = wr_en && (paddr == OFF_CTRL) && pwdata[CTRL_CLR_BIT];
  assign conversion_go = (wr_en && (paddr == OFF_CTRL) && pwdata[CTRL_GO_BIT]) || ext_trigger;
  // samples arriving while a clear is still running are dropped
  assign take = conv_valid && (clear_cnt == 4'h0);
  assign compute = take && (!double_sample_enable || phase == ARC_PH_SECOND);
  assign filter_output = arc_ashr(accumulator, shift_amount); // [RQ14] [RQ10]
  // error is taken as the shifted next accumulator value; calculation choices are outside this unit
  assign error_value = arc_ashr(acc_sum, shift_amount);
  assign restart = (compute_mode_select == MODE_AVG) && (sample_counter >= repeat_target); // [RQ6]

  // sample selection
  always_comb begin
    if (double_sample_enable) begin
      sample = ACC_W'(conv_result) - ACC_W'(previous_result); // [RQ9]
    end else begin
      sample = ACC_W'(conv_result); // [RQ9]
    end
  end

  arc_accum u_accum (
    .mode(compute_mode_select),
    .shift(shift_amount),
    .restart(restart),
    .acc(accumulator),
    .sample(sample),
    .next_acc(acc_sum),
    .overflow(acc_ovf)
  );

  arc_threshold u_threshold (
    .err(error_value),
    .upper(upper_threshold),
    .lower(lower_threshold),
    .tmode(threshold_mode),
    .hit(thr_hit)
  );

  // read decode
  always_comb begin
    rd_word = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      OFF_CTRL: begin
        rd_word[CTRL_MODE_LSB +: 3] = compute_mode_select;
        rd_word[CTRL_SHIFT_LSB +: 3] = shift_amount;
        rd_word[CTRL_DSEN_BIT] = double_sample_enable;
        rd_word[CTRL_RCSEL_BIT] = rc_clock_select;
      end
      OFF_REPEAT: rd_word[CNT_W-1:0] = repeat_target;
      OFF_UPPER: rd_word[ACC_W-1:0] = upper_threshold;
      OFF_LOWER: rd_word[ACC_W-1:0] = lower_threshold;
      OFF_TMODE: rd_word[2:0] = threshold_mode;
      OFF_ACC: rd_word[ACC_W-1:0] = accumulator; // [RQ11]
      OFF_STAT: begin
        rd_word[CNT_W-1:0] = sample_counter; // [RQ19]
        rd_word[STAT_OVF_BIT] = accumulator_overflow_flag;
        rd_word[STAT_BUSY_BIT] = clear_cnt != 4'h0;
        rd_word[STAT_PHASE_BIT] = phase == ARC_PH_SECOND;
      end
      OFF_FILTER: rd_word[ACC_W-1:0] = filter_output;
      OFF_RESULT: begin
        rd_word[RES_W-1:0] = conversion_result;
        rd_word[RESULT_PREV_LSB +: RES_W] = previous_result;
      end
      OFF_IRQ_STATUS: rd_word[IRQ_W-1:0] = irq_status;
      OFF_IRQ_MASK: rd_word[IRQ_W-1:0] = irq_mask;
      OFF_ERROR: rd_word[ACC_W-1:0] = error_value;
      default: mapped = 1'b0;
    endcase
  end

  // bus handshake: one wait state, answer in the second access cycle
  always_comb begin
    next_pready = psel && penable && !pready;
    next_pslverr = psel && penable && !pready && !mapped;
    next_prdata = 32'h0000_0000;
    if (psel && penable && !pready && !pwrite) begin
      next_prdata = rd_word;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  // software control registers
  always_comb begin
    next_mode = compute_mode_select;
    next_shift = shift_amount;
    next_dsen = double_sample_enable;
    next_rcsel = rc_clock_select;
    next_repeat = repeat_target;
    next_upper = upper_threshold;
    next_lower = lower_threshold;
    next_tmode = threshold_mode;
    next_irq_mask = irq_mask;
    if (wr_en) begin
      case (paddr)
        OFF_CTRL: begin
          next_mode = pwdata[CTRL_MODE_LSB +: 3]; // [RQ1]
          next_shift = pwdata[CTRL_SHIFT_LSB +: 3]; // [RQ14] [RQ15]
          next_dsen = pwdata[CTRL_DSEN_BIT];
          next_rcsel = pwdata[CTRL_RCSEL_BIT];
        end
        OFF_REPEAT: next_repeat = pwdata[CNT_W-1:0];
        OFF_UPPER: next_upper = pwdata[ACC_W-1:0];
        OFF_LOWER: next_lower = pwdata[ACC_W-1:0];
        OFF_TMODE: next_tmode = pwdata[2:0];
        OFF_IRQ_MASK: next_irq_mask = pwdata[IRQ_W-1:0];
        default: next_mode = compute_mode_select;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      compute_mode_select <= MODE_BASIC;
      shift_amount <= 3'h0;
      double_sample_enable <= 1'b0;
      rc_clock_select <= 1'b0;
      repeat_target <= REPEAT_RST;
      upper_threshold <= THR_RST;
      lower_threshold <= THR_RST;
      threshold_mode <= TM_NEVER;
      irq_mask <= '0;
    end else begin
      compute_mode_select <= next_mode;
      shift_amount <= next_shift;
      double_sample_enable <= next_dsen;
      rc_clock_select <= next_rcsel;
      repeat_target <= next_repeat;
      upper_threshold <= next_upper;
      lower_threshold <= next_lower;
      threshold_mode <= next_tmode;
      irq_mask <= next_irq_mask;
    end
  end

  // computation, sequencing and interrupt state
  always_comb begin
    next_accumulator = accumulator;
    next_sample_counter = sample_counter;
    next_ovf = accumulator_overflow_flag;
    next_result = conversion_result;
    next_prev = previous_result;
    next_phase = phase;
    next_clear_cnt = clear_cnt;
    next_conv_start = conversion_go;
    irq_set = '0;
    if (clear_cnt != 4'h0) begin
      next_clear_cnt = clear_cnt - 4'h1;
    end
    if (take) begin
      if (double_sample_enable && phase == ARC_PH_FIRST) begin
        next_prev = conv_result; // [RQ9]
        next_phase = ARC_PH_SECOND;
      end else begin
        next_prev = double_sample_enable ? previous_result : conversion_result;
        next_result = conv_result;
        next_phase = ARC_PH_FIRST;
      end
      // non-basic modes flag each conversion
      if (compute_mode_select != MODE_BASIC) begin
        irq_set[IRQ_DONE] = 1'b1; // [RQ5]
      end
    end
    if (compute) begin
      case (compute_mode_select)
        MODE_ACCUM, MODE_LPF: begin
          next_accumulator = acc_sum; // [RQ4] [RQ8]
          if (sample_counter != {CNT_W{1'b1}}) begin
            next_sample_counter = sample_counter + CNT_W'(1); // [RQ4] [RQ19]
          end
        end
        MODE_AVG: begin
          next_accumulator = acc_sum; // [RQ6]
          next_sample_counter = restart ? CNT_W'(1) : sample_counter + CNT_W'(1); // [RQ6]
        end
        MODE_BURST: begin
          next_accumulator = acc_sum;
          if (sample_counter != {CNT_W{1'b1}}) begin
            next_sample_counter = sample_counter + CNT_W'(1);
          end
        end
        default: irq_set[IRQ_DONE] = 1'b1; // [RQ2] [RQ3]
      endcase
      if (compute_mode_select != MODE_BASIC && compute_mode_select <= MODE_LPF) begin
        if (acc_ovf) begin
          next_ovf = 1'b1;
          irq_set[IRQ_OVF] = 1'b1;
        end
        // accumulate tests every sample, the others from the repeat target on
        if ((compute_mode_select == MODE_ACCUM || next_sample_counter >= repeat_target) &&
            (thr_hit || next_ovf)) begin
          irq_set[IRQ_THR] = 1'b1; // [RQ5] [RQ6] [RQ8] [RQ18]
        end
        if (compute_mode_select == MODE_BURST && next_sample_counter < repeat_target) begin
          next_conv_start = 1'b1; // [RQ7]
        end
      end
    end
    if (conversion_go) begin
      next_phase = ARC_PH_FIRST;
      if (compute_mode_select == MODE_BURST || restart) begin
        next_accumulator = '0; // [RQ7] [RQ16]
        next_sample_counter = '0;
      end
    end
    if (accumulator_clear) begin
      next_accumulator = '0; // [RQ12]
      next_sample_counter = '0;
      next_ovf = 1'b0;
      // on the rc oscillator the clear keeps the unit busy for its cycles
      next_clear_cnt = rc_clock_select ? CLEAR_RC_CYCLES : 4'h0; // [RQ13]
    end
    // set wins over a same-cycle write-one-to-clear
    next_irq_status = irq_status | irq_set;
    if (wr_en && paddr == OFF_IRQ_STATUS) begin
      next_irq_status = (irq_status & ~pwdata[IRQ_W-1:0]) | irq_set;
    end
    next_irq = |(next_irq_status & next_irq_mask);
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      accumulator <= '0;
      sample_counter <= '0;
      accumulator_overflow_flag <= 1'b0;
      conversion_result <= '0;
      previous_result <= '0;
      phase <= ARC_PH_FIRST;
      clear_cnt <= 4'h0;
      irq_status <= '0;
      conv_start <= 1'b0;
      irq <= 1'b0;
    end else begin
      accumulator <= next_accumulator;
      sample_counter <= next_sample_counter;
      accumulator_overflow_flag <= next_ovf;
      conversion_result <= next_result;
      previous_result <= next_prev;
      phase <= next_phase;
      clear_cnt <= next_clear_cnt;
      irq_status <= next_irq_status;
      conv_start <= next_conv_start;
      irq <= next_irq;
    end
  end
endmodule
`default_nettype wire

/* File: src/arc_threshold.sv */
// signed window comparison of the error value against two thresholds
// assumes thresholds are two's complement like the error value
`timescale 1ns/100ps
`default_nettype none
module arc_threshold
  import arc_pkg::*;
(
  // operands
  input wire logic signed [arc_pkg::ACC_W-1:0] err,
  input wire logic signed [arc_pkg::ACC_W-1:0] upper,
  input wire logic signed [arc_pkg::ACC_W-1:0] lower,
  // selection and result
  input wire logic [2:0] tmode,
  output logic hit
);
  logic lo_fail;
  logic up_fail;

  always_comb begin
    lo_fail = err < lower; // [RQ17]
    up_fail = err > upper; // [RQ17]
    case (tmode)
      TM_NEVER: hit = 1'b0;
      TM_BELOW_LO: hit = lo_fail;
      TM_AT_LEAST_LO: hit = !lo_fail;
      TM_INSIDE: hit = !lo_fail && !up_fail;
      TM_OUTSIDE: hit = lo_fail || up_fail;
      TM_AT_MOST_UP: hit = !up_fail;
      TM_ABOVE_UP: hit = up_fail;
      default: hit = 1'b1;
    endcase
  end
endmodule
`default_nettype wire

/* File: verification/arc_core_model.sv */
// stand-in for the conversion core: answers each start after a fixed latency
// assumes starts arrive as one-cycle pulses on clk_sys
`timescale 1ns/100ps
`default_nettype none
module arc_core_model #(
  parameter int LAT = 10
)(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // requests
  input wire logic conv_start,
  input wire logic bench_req,
  input wire logic [arc_pkg::RES_W-1:0] bench_data,
  // result
  output logic conv_valid,
  output logic [arc_pkg::RES_W-1:0] conv_result
);
  int cnt;
  logic [arc_pkg::RES_W-1:0] last;
  always_ff @(posedge clk_sys) begin
    conv_valid <= 1'b0;
    // result is not held outside its valid cycle
    conv_result <= ~last;
    if (!resetn) begin
      cnt <= 0;
      last <= '0;
    end else if ((conv_start || bench_req) && cnt == 0) begin
      cnt <= LAT;
    end else if (cnt == 1) begin
      conv_valid <= 1'b1;
      conv_result <= bench_data;
      last <= bench_data;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

/* File: verification/arc_result_computation_assertions.sv */
// port-level checks of the result computation unit
// assumes software rewrites mode with every control write
`timescale 1ns/100ps
`default_nettype none
module arc_result_computation_assertions
  import arc_pkg::*;
#(
  parameter int RES_W = 10
)(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // apb
  input wire logic [arc_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // core and interrupt
  input wire logic conv_valid,
  input wire logic [RES_W-1:0] conv_result,
  input wire logic ext_trigger,
  input wire logic conv_start,
  input wire logic irq
);
  logic wr_done;
  logic [2:0] mode_q;
  logic [2:0] mask_q;
  assign wr_done = psel && penable && pready && pwrite;
  // shadow of mode and mask, taken at the completing edge
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      mode_q <= 3'h0;
      mask_q <= 3'h0;
    end else if (wr_done && paddr == OFF_CTRL) begin
      mode_q <= pwdata[2:0];
    end else if (wr_done && paddr == OFF_IRQ_MASK) begin
      mask_q <= pwdata[2:0];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_access_two: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered in its second cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer cycle");
  a_go_starts: assert property (wr_done && paddr == OFF_CTRL && pwdata[CTRL_GO_BIT] |=> conv_start)
    else $error("go write gave no start");
  a_trig_starts: assert property (ext_trigger |=> conv_start)
    else $error("trigger gave no start");
  a_done_irq: assert property (conv_valid && mode_q != MODE_BASIC && mask_q[IRQ_DONE] |=> irq)
    else $error("conversion did not raise done interrupt");
  a_irq_masked: assert property (mask_q == 3'h0 && $past(mask_q) == 3'h0 |-> !irq)
    else $error("interrupt while fully masked");
endmodule
bind arc_result_computation arc_result_computation_assertions #(.RES_W(RES_W)) chk_u (.clk_sys(clk_sys),
  .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_valid(conv_valid), .conv_result(conv_result),
  .ext_trigger(ext_trigger), .conv_start(conv_start), .irq(irq));
`default_nettype wire

/* File: verification/arc_result_computation_bench.sv */
// self-checking bench of the result computation unit
// assumes the core stand-in answers each request after a fixed latency
`timescale 1ns/100ps
`default_nettype none
module arc_result_computation_bench;
  import arc_pkg::*;
  logic clk_sys, resetn, psel, penable, pwrite, ext_trigger, req;
  logic pready, pslverr, conv_valid, conv_start, irq, se;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [RES_W-1:0] conv_result, data;
  int err_count, total_checks;
  int starts = 0;

  arc_result_computation dut_u (.clk_sys(clk_sys), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_valid(conv_valid), .conv_result(conv_result), .ext_trigger(ext_trigger), .conv_start(conv_start),
    .irq(irq));
  arc_core_model core_u (.clk_sys(clk_sys), .resetn(resetn), .conv_start(conv_start), .bench_req(req),
    .bench_data(data), .conv_valid(conv_valid), .conv_result(conv_result));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (conv_start === 1'b1) starts <= starts + 1;

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic timeout;
    err_count++;
    stop_test;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) timeout;
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic get(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask
  task automatic wait_valid;
    int n;
    n = 0;
    while (conv_valid !== 1'b1) begin
      @(posedge clk_sys);
      n++;
      if (n > 60) timeout;
    end
    @(posedge clk_sys);
  endtask
  task automatic conv(input logic [9:0] v);
    data <= v;
    req <= 1'b1;
    @(posedge clk_sys);
    req <= 1'b0;
    wait_valid;
  endtask

  task automatic t_reset;
    get(OFF_CTRL, 32'h0000_0000);
    get(OFF_REPEAT, 32'h0000_0001);
    get(OFF_STAT, 32'h0000_0000);
    get(8'h30, 32'h0000_0000);
    check({31'h0, se}, 32'h0000_0001);
  endtask
  task automatic t_accum;
    put(OFF_CTRL, 32'h0000_0011);
    put(OFF_IRQ_MASK, 32'h0000_0001);
    conv(10'h005);
    check({31'h0, irq}, 32'h0000_0001);
    conv(10'h00A);
    get(OFF_ACC, 32'h0000_000F);
    get(OFF_STAT, 32'h0000_0002);
    get(OFF_FILTER, 32'h0000_0007);
    put(OFF_IRQ_STATUS, 32'h0000_0007);
    check({31'h0, irq}, 32'h0000_0000);
  endtask
  task automatic t_ovf;
    put(OFF_CTRL, 32'h0000_0001);
    repeat (256) conv(10'h0C8);
    get(OFF_STAT, 32'h0000_01FF);
    get(OFF_IRQ_STATUS, 32'h0000_0007);
    put(OFF_IRQ_STATUS, 32'h0000_0007);
  endtask
  task automatic t_clear;
    // rc select stretches the clear over five cycles; it must stand before the clear
    put(OFF_CTRL, 32'h0000_0201);
    put(OFF_CTRL, 32'h0001_0201);
    get(OFF_STAT, 32'h0000_0200);
    repeat (6) @(posedge clk_sys);
    get(OFF_STAT, 32'h0000_0000);
    get(OFF_ACC, 32'h0000_0000);
  endtask
  task automatic t_avg;
    put(OFF_CTRL, 32'h0000_0002);
    put(OFF_REPEAT, 32'h0000_0002);
    conv(10'h003);
    conv(10'h005);
    get(OFF_ACC, 32'h0000_0008);
    conv(10'h007);
    get(OFF_ACC, 32'h0000_0007);
    get(OFF_STAT, 32'h0000_0001);
    conv(10'h009);
    data <= 10'h004;
    put(OFF_CTRL, 32'h0002_0002);
    get(OFF_ACC, 32'h0000_0000);
    wait_valid;
    get(OFF_ACC, 32'h0000_0004);
  endtask
  task automatic t_burst;
    int s0;
    put(OFF_CTRL, 32'h0000_0003);
    put(OFF_REPEAT, 32'h0000_0003);
    put(OFF_TMODE, 32'h0000_0007);
    put(OFF_IRQ_STATUS, 32'h0000_0007);
    data <= 10'h006;
    s0 = starts;
    put(OFF_CTRL, 32'h0002_0003);
    repeat (3) wait_valid;
    get(OFF_ACC, 32'h0000_0012);
    get(OFF_IRQ_STATUS, 32'h0000_0003);
    check(32'(starts - s0), 32'h0000_0003);
    s0 = starts;
    ext_trigger <= 1'b1;
    @(posedge clk_sys);
    ext_trigger <= 1'b0;
    repeat (3) wait_valid;
    get(OFF_STAT, 32'h0000_0003);
    get(OFF_ACC, 32'h0000_0012);
    check(32'(starts - s0), 32'h0000_0003);
  endtask
  task automatic t_lpf;
    put(OFF_CTRL, 32'h0001_0014);
    repeat (6) @(posedge clk_sys);
    put(OFF_IRQ_STATUS, 32'h0000_0007);
    conv(10'h008);
    conv(10'h008);
    get(OFF_ACC, 32'h0000_000C);
    get(OFF_FILTER, 32'h0000_0006);
    get(OFF_IRQ_STATUS, 32'h0000_0001);
    conv(10'h008);
    get(OFF_ACC, 32'h0000_000E);
    get(OFF_IRQ_STATUS, 32'h0000_0003);
  endtask
  task automatic t_double;
    put(OFF_CTRL, 32'h0000_0100);
    put(OFF_IRQ_STATUS, 32'h0000_0007);
    conv(10'h064);
    get(OFF_IRQ_STATUS, 32'h0000_0000);
    conv(10'h028);
    get(OFF_IRQ_STATUS, 32'h0000_0001);
    get(OFF_ACC, 32'h0000_000E);
    get(OFF_RESULT, 32'h0064_0028);
    put(OFF_CTRL, 32'h0001_0101);
    repeat (6) @(posedge clk_sys);
    put(OFF_TMODE, 32'h0000_0001);
    put(OFF_IRQ_STATUS, 32'h0000_0007);
    conv(10'h028);
    conv(10'h01E);
    get(OFF_ACC, 32'h0000_FFF6);
    get(OFF_IRQ_STATUS, 32'h0000_0003);
    // error stays -10; an unsigned test against +5 would wrongly fire
    put(OFF_UPPER, 32'h0000_0005);
    put(OFF_TMODE, 32'h0000_0006);
    put(OFF_IRQ_STATUS, 32'h0000_0007);
    conv(10'h028);
    conv(10'h028);
    get(OFF_IRQ_STATUS, 32'h0000_0001);
  endtask

  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    ext_trigger = 1'b0;
    req = 1'b0;
    data = 10'h000;
    err_count = 0;
    total_checks = 0;
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    t_reset;
    t_accum;
    t_ovf;
    t_clear;
    t_avg;
    t_burst;
    t_lpf;
    t_double;
    stop_test;
  end
endmodule
`default_nettype wire
